// ### src/pmc_consts.vh
`ifndef PMC_CONSTS_VH
`define PMC_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PMC_ADR_MODE      4'h0
`define PMC_ADR_TMR_CTRL  4'h4
`define PMC_ADR_STATUS    4'h8
`define PMC_ADR_CMD       4'hc

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PMC_MODE_SCS_LO   0
`define PMC_MODE_IDLE_ON_SLEEP_ENABLE    2
`define PMC_TC_OSCEN      3
`define PMC_TC_SECACT     6
`define PMC_ST_OSC_STARTUP_DONE_FLAG       0
`define PMC_ST_INTOSC_STABLE_FLAG       1
`define PMC_ST_MODE_LO    4
`define PMC_CMD_SLEEP     0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PMC_RST_MODE      3'h0
`define PMC_RST_TC        8'h00

// ----------------------------------------
// Clock select codes
// ----------------------------------------
`define PMC_SEL_PRI       2'h0
`define PMC_SEL_SEC       2'h1
`define PMC_SEL_INT       2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define PMC_CLK_HZ        20000000
`define PMC_WAKE_NS       10000
`define PMC_WAKE_CYC      ((`PMC_WAKE_NS * (`PMC_CLK_HZ / 1000000)) / 1000)
`define PMC_SYNC_HOLD     2'h2

`endif

// ### src/pmc_clk_sw.v
`timescale 1ns/1ps
`include "pmc_consts.vh"
// Glitch-free source selector: the requested source's enable only opens
// after the other has been closed for a sync-hold of cycles.
module pmc_clk_sw
#(
    parameter N = 3
)
(
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst_n,
    // Request and status
    input  wire [1:0]   sel_req,
    input  wire [N-1:0] src_ok,
    output reg  [N-1:0] gate_en_r,
    output reg  [1:0]   sel_cur_r
);

    reg [1:0] wait_r;
    integer   i;

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_en_r <= {{(N-1){1'b0}}, 1'b1};
            sel_cur_r <= 2'h0;
            wait_r    <= 2'h0;
        end
        else if (sel_req != sel_cur_r)
        begin
            // Break before make
            gate_en_r <= {N{1'b0}};
            if (wait_r == 2'h0)
                wait_r <= 2'h1;
            else if (wait_r == `PMC_SYNC_HOLD && src_ok[sel_req])
            begin
                sel_cur_r <= sel_req;
                wait_r    <= 2'h0;
            end
            else if (wait_r != `PMC_SYNC_HOLD)
                wait_r <= wait_r + 2'h1;
        end
        else
        begin
            for (i = 0; i < N; i = i + 1)
                gate_en_r[i] <= (i == sel_cur_r) && src_ok[i];
        end
    end

endmodule

// ### src/pmc_top.v
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "pmc_consts.vh"

module pmc_top
#(
    parameter WAKE_CYC = `PMC_WAKE_CYC
)
(
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Core events
    input  wire        sleep_exec,
    input  wire        wake_evt,
    input  wire        wdt_timeout,
    input  wire        intosc_is_primary,
    // Oscillator status pins
    input  wire        pri_osc_ready,
    input  wire        sec_osc_running,
    input  wire        int_osc_stable,
    // Oscillator and clock gate controls
    output reg         pri_osc_en_r,
    output reg         sec_osc_en_r,
    output reg         cpu_clk_en_r,
    output reg         per_clk_en_r,
    output reg  [2:0]  src_gate_r,
    output reg         wdt_reset_r
);

    // ----------------------------------------
    // Mode states
    // ----------------------------------------
    localparam ST_PRIMARY_RUN_MODE  = 3'h0;
    localparam ST_PRIMARY_IDLE_MODE = 3'h1;
    localparam ST_IDLE_WK  = 3'h2;
    localparam ST_SECONDARY_RUN_MODE  = 3'h3;
    localparam ST_SEC_BACK = 3'h4;
    localparam ST_INT_RUN  = 3'h5;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [2:0] sync1_r;
    reg [2:0] sync2_r;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {int_osc_stable, sec_osc_running, pri_osc_ready};
            sync2_r <= sync1_r;
        end
    end
    wire pri_ok = sync2_r[0];
    wire sec_ok = sync2_r[1];
    wire int_ok = sync2_r[2];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [1:0]  scs_r;
    reg        idle_on_sleep_enable_r;
    reg        osc_en_bit_r;
    reg [6:0]  tc_other_r;
    reg        secact_r;
    reg        osc_startup_done_flag_r;
    reg [2:0]  state_r;
    reg [2:0]  state_nxt;
    reg [15:0] wake_cnt_r;
    reg        forced_r;

    wire wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_mode = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PMC_ADR_MODE;
    wire wr_tc   = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PMC_ADR_TMR_CTRL;
    wire wr_cmd  = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PMC_ADR_CMD;
    wire sleep_p = sleep_exec || (wr_cmd && wb_dat_i[`PMC_CMD_SLEEP]);

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {idle_on_sleep_enable_r, scs_r}           <= `PMC_RST_MODE;
            {tc_other_r, osc_en_bit_r} <= `PMC_RST_TC;
        end
        else
        begin
            // Mode bits only change by a write; wake leaves them alone
            if (wr_mode)
            begin
                scs_r   <= wb_dat_i[`PMC_MODE_SCS_LO +: 2];
                idle_on_sleep_enable_r <= wb_dat_i[`PMC_MODE_IDLE_ON_SLEEP_ENABLE];
            end
            if (wr_tc)
            begin
                osc_en_bit_r <= wb_dat_i[`PMC_TC_OSCEN];
                tc_other_r   <= {wb_dat_i[7], wb_dat_i[5:4], wb_dat_i[2:0], 1'b0};
            end
            else if (state_r == ST_SEC_BACK && pri_ok && forced_r)
                osc_en_bit_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Bus answer
    // ----------------------------------------
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0;
            if (wb_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `PMC_ADR_MODE:
                        wb_dat_o <= {29'h0, idle_on_sleep_enable_r, scs_r};
                    // Active flag at bit 6
                    `PMC_ADR_TMR_CTRL:
                        wb_dat_o <= {24'h0, tc_other_r[6], secact_r, tc_other_r[5:4],
                                     osc_en_bit_r, tc_other_r[3:1]};
                    `PMC_ADR_STATUS:
                        wb_dat_o <= {25'h0, state_r, 2'h0,
                                     int_ok && intosc_is_primary, osc_startup_done_flag_r};
                    default:
                        wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Mode machine
    // ----------------------------------------
    wire run_mode = state_r == ST_SECONDARY_RUN_MODE || state_r == ST_INT_RUN;

    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_PRIMARY_RUN_MODE:
                if (sleep_p && !idle_on_sleep_enable_r)
                begin
                    if (scs_r == `PMC_SEL_SEC)
                    begin
                        if (osc_en_bit_r)
                            state_nxt = ST_SECONDARY_RUN_MODE;
                        // Request dropped without enable
                    end
                    else if (scs_r[1])
                        state_nxt = ST_INT_RUN;
                end
                else if (sleep_p && scs_r == `PMC_SEL_PRI)
                    state_nxt = ST_PRIMARY_IDLE_MODE;
            ST_PRIMARY_IDLE_MODE:
                if (wake_evt || wdt_timeout)
                    state_nxt = ST_IDLE_WK;
            ST_IDLE_WK:
                if (wake_cnt_r == WAKE_CYC[15:0])
                    state_nxt = ST_PRIMARY_RUN_MODE;
            ST_SECONDARY_RUN_MODE:
                if (wake_evt || !osc_en_bit_r)
                    state_nxt = ST_SEC_BACK;
                else if (sleep_p && idle_on_sleep_enable_r)
                    state_nxt = ST_SECONDARY_RUN_MODE;
            ST_SEC_BACK:
                if (pri_ok)
                    state_nxt = ST_PRIMARY_RUN_MODE;
            ST_INT_RUN:
                if (wake_evt)
                    state_nxt = ST_PRIMARY_RUN_MODE;
            default:
                state_nxt = ST_PRIMARY_RUN_MODE;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r     <= ST_PRIMARY_RUN_MODE;
            wake_cnt_r  <= 16'h0;
            forced_r    <= 1'b0;
            secact_r    <= 1'b0;
            osc_startup_done_flag_r      <= 1'b1;
            wdt_reset_r <= 1'b0;
        end
        else
        begin
            // Watchdog in secondary or internal run resets, not wakes
            wdt_reset_r <= wdt_timeout && run_mode;
            if (wdt_timeout && run_mode)
                state_r <= ST_PRIMARY_RUN_MODE;
            else
                state_r <= state_nxt;
            wake_cnt_r <= (state_r == ST_IDLE_WK) ? wake_cnt_r + 16'h1 : 16'h0;
            if (state_r == ST_SECONDARY_RUN_MODE && !osc_en_bit_r)
                forced_r <= 1'b1;
            else if (state_r != ST_SEC_BACK)
                forced_r <= 1'b0;
            if (state_nxt == ST_SECONDARY_RUN_MODE && state_r == ST_PRIMARY_RUN_MODE)
            begin
                secact_r <= 1'b1;
                osc_startup_done_flag_r   <= 1'b0;
            end
            else if ((state_r == ST_SEC_BACK && pri_ok) || (wdt_timeout && run_mode))
            begin
                secact_r <= 1'b0;
                osc_startup_done_flag_r   <= 1'b1;
            end
            else if (state_r == ST_INT_RUN && state_nxt == ST_PRIMARY_RUN_MODE)
                osc_startup_done_flag_r <= 1'b1;
            else if (state_r == ST_PRIMARY_RUN_MODE && state_nxt == ST_INT_RUN)
                osc_startup_done_flag_r <= 1'b0;
            // Idle and its wake leave the flag untouched
        end
    end

    // ----------------------------------------
    // Source selection and gates
    // ----------------------------------------
    reg [1:0] sel_req;
    always @*
    begin
        case (state_r)
            ST_SECONDARY_RUN_MODE, ST_SEC_BACK: sel_req = `PMC_SEL_SEC;
            ST_INT_RUN:              sel_req = `PMC_SEL_INT;
            default:                 sel_req = `PMC_SEL_PRI;
        endcase
    end

    wire [2:0] gate_en;
    wire [1:0] sel_cur;

    pmc_clk_sw #(
        .N (3)
    ) u_sw (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .sel_req   (sel_req),
        .src_ok    ({int_ok, sec_ok, pri_ok}),
        .gate_en_r (gate_en),
        .sel_cur_r (sel_cur)
    );

    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pri_osc_en_r <= 1'b1;
            sec_osc_en_r <= 1'b0;
            cpu_clk_en_r <= 1'b1;
            per_clk_en_r <= 1'b1;
            src_gate_r   <= 3'h1;
        end
        else
        begin
            // Primary off only for secondary run, one cycle behind state_r, before the secondary has started
            pri_osc_en_r <= state_r != ST_SECONDARY_RUN_MODE;
            // Secondary stays up after wake switchback
            // Kept alive until the selector has left it, even when forced off
            sec_osc_en_r <= osc_en_bit_r || state_r == ST_SECONDARY_RUN_MODE || state_r == ST_SEC_BACK
                            || sel_cur == `PMC_SEL_SEC;
            src_gate_r   <= gate_en;
            // Clocks held until the chosen source runs
            per_clk_en_r <= |gate_en;
            cpu_clk_en_r <= (|gate_en) && state_r != ST_PRIMARY_IDLE_MODE
                            && state_r != ST_IDLE_WK;
        end
    end

endmodule

// ### verif/pmc_top_sva.sv
`timescale 1ns/1ps
// ----
// Clock switch checker
// ----
module pmc_top_sva
#(
    parameter WAKE_CYC = 200
)
(
    // Clock and reset
    input wire       clk_sys,
    input wire       rst_n,
    // Events and status
    input wire       wake_evt,
    input wire       wdt_timeout,
    input wire       pri_osc_ready,
    input wire       sec_osc_running,
    // Controls
    input wire       pri_osc_en_r,
    input wire       sec_osc_en_r,
    input wire       cpu_clk_en_r,
    input wire       per_clk_en_r,
    input wire [2:0] src_gate_r,
    input wire       wdt_reset_r
);
    localparam int LIM = WAKE_CYC + 8;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_idle_wake;
        !cpu_clk_en_r && per_clk_en_r && wake_evt;
    endsequence
    sequence s_resume;
        !cpu_clk_en_r [*3] ##[1:LIM] cpu_clk_en_r;
    endsequence
    property p_wake; s_idle_wake |=> s_resume; endproperty
    property p_idle; !cpu_clk_en_r && per_clk_en_r |-> pri_osc_en_r; endproperty
    property p_onehot; $onehot0(src_gate_r); endproperty
    property p_break;
        src_gate_r != 3'h0 && $past(src_gate_r) != 3'h0 |-> $stable(src_gate_r);
    endproperty
    property p_sec_gate; src_gate_r[1] |-> $past(sec_osc_running, 2); endproperty
    property p_pri_gate; $rose(src_gate_r[0]) |-> $past(pri_osc_ready, 2); endproperty
    property p_sec_off; $fell(sec_osc_en_r) |-> !src_gate_r[1] && pri_osc_en_r; endproperty
    property p_wdt_cause;
        wdt_reset_r |-> $past(wdt_timeout) || $past(wdt_timeout, 2);
    endproperty
    property p_wdt_pulse; wdt_reset_r |=> !wdt_reset_r; endproperty
    a_wake: assert property (p_wake) else $error("cpu resume timing");
    a_idle: assert property (p_idle) else $error("idle without primary");
    a_onehot: assert property (p_onehot) else $error("two sources gated");
    a_break: assert property (p_break) else $error("source switch glitch");
    a_sec_gate: assert property (p_sec_gate) else $error("secondary not started");
    a_pri_gate: assert property (p_pri_gate) else $error("primary not ready");
    a_sec_off: assert property (p_sec_off) else $error("secondary off early");
    a_wdt_cause: assert property (p_wdt_cause) else $error("stray wdt reset");
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("wdt reset too long");
endmodule

bind pmc_top pmc_top_sva #(.WAKE_CYC(WAKE_CYC)) i_pmc_top_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .wake_evt(wake_evt), .wdt_timeout(wdt_timeout),
    .pri_osc_ready(pri_osc_ready), .sec_osc_running(sec_osc_running),
    .pri_osc_en_r(pri_osc_en_r), .sec_osc_en_r(sec_osc_en_r),
    .cpu_clk_en_r(cpu_clk_en_r), .per_clk_en_r(per_clk_en_r),
    .src_gate_r(src_gate_r), .wdt_reset_r(wdt_reset_r));

// ### verif/pmc_osc_model.sv
`timescale 1ns/1ps
// ----
// Oscillator sources
// ----
module pmc_osc_model
(
    // Clock and reset
    input  wire       clk_sys,
    input  wire       rst_n,
    // Start-up lengths, prompt or slow
    input  wire [7:0] pri_dly,
    input  wire [7:0] sec_dly,
    // Enables
    input  wire       pri_osc_en_r,
    input  wire       sec_osc_en_r,
    // Status
    output wire       pri_osc_ready,
    output wire       sec_osc_running,
    output wire       int_osc_stable
);
    reg [7:0] pri_cnt_r;
    reg [7:0] sec_cnt_r;
    reg       int_ok_r;
    // Ready only after a full start-up count
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pri_cnt_r <= 8'h00;
            sec_cnt_r <= 8'h00;
            int_ok_r  <= 1'b0;
        end
        else
        begin
            pri_cnt_r <= pri_osc_en_r ? pri_cnt_r + {7'h00, pri_cnt_r < pri_dly} : 8'h00;
            sec_cnt_r <= sec_osc_en_r ? sec_cnt_r + {7'h00, sec_cnt_r < sec_dly} : 8'h00;
            int_ok_r  <= 1'b1;
        end
    end
    assign pri_osc_ready   = pri_osc_en_r && pri_cnt_r == pri_dly;
    assign sec_osc_running = sec_osc_en_r && sec_cnt_r == sec_dly;
    assign int_osc_stable  = int_ok_r;
endmodule

// ### verif/power_managed_mode_clock_switch_tb.sv
`timescale 1ns/1ps
module power_managed_mode_clock_switch_tb;
    typedef struct packed {logic we; logic [3:0] adr; logic [31:0] dat;} pmc_row_t;
    localparam int WK = 4;
    logic clk_sys = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0, q, rd;
    logic ack, sleep_exec = 0, wake_evt = 0, wdt_timeout = 0, wdt_seen = 0;
    logic intosc_pri = 1'b1;
    logic pri_rdy, secondary_run_mode, int_ok, pri_en, sec_en, cpu_en, per_en, wdt_rst;
    logic [2:0] gate;
    logic [7:0] pri_dly = 8'h03, sec_dly = 8'h03;
    int miscompares = 0, cmp_count = 0, n;
    pmc_row_t rows[7] = '{'{1'b1, 4'h0, 32'h5}, '{1'b0, 4'h0, 32'h5},
        '{1'b1, 4'h4, 32'hff}, '{1'b0, 4'h4, 32'hbf}, '{1'b1, 4'h2, 32'ha5},
        '{1'b0, 4'h2, 32'h0}, '{1'b0, 4'h8, 32'h3}};
    pmc_top #(.WAKE_CYC(WK)) i_pmc_top (.clk_sys(clk_sys), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .sleep_exec(sleep_exec),
        .wake_evt(wake_evt), .wdt_timeout(wdt_timeout), .intosc_is_primary(intosc_pri),
        .pri_osc_ready(pri_rdy), .sec_osc_running(secondary_run_mode), .int_osc_stable(int_ok),
        .pri_osc_en_r(pri_en), .sec_osc_en_r(sec_en), .cpu_clk_en_r(cpu_en),
        .per_clk_en_r(per_en), .src_gate_r(gate), .wdt_reset_r(wdt_rst));
    pmc_osc_model i_pmc_osc_model (.clk_sys(clk_sys), .rst_n(rst_n), .pri_dly(pri_dly),
        .sec_dly(sec_dly), .pri_osc_en_r(pri_en), .sec_osc_en_r(sec_en),
        .pri_osc_ready(pri_rdy), .sec_osc_running(secondary_run_mode), .int_osc_stable(int_ok));
    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (wdt_rst === 1'b1) wdt_seen <= 1'b1;
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        k = 0;
        do @(posedge clk_sys); while (ack !== 1'b1 && ++k < 50);
        q = rd;
        if (k >= 50)
        begin
            miscompares++;
            $display("[ERR] %0t bus ack timeout", $time);
        end
        {cyc, stb} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic ev(input logic [2:0] k);
        @(posedge clk_sys);
        {wdt_timeout, wake_evt, sleep_exec} <= k;
        @(posedge clk_sys);
        {wdt_timeout, wake_evt, sleep_exec} <= 3'h0;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    task automatic wgate(input logic [2:0] g);
        n = 0;
        while (gate !== g && n++ < 200) @(posedge clk_sys);
        chk(gate, g, "gate wait");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        wt(16);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            wb(rows[i].we, rows[i].adr, rows[i].dat);
            if (!rows[i].we) chk(q, rows[i].dat, "reg row");
        end
        $display("done: registers");
        wb(1'b1, 4'h0, 32'h4);
        ev(3'h1);
        wt(2);
        chk({cpu_en, per_en, pri_en}, 3'b011, "idle gates");
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h13, "idle status");
        ev(3'h2);
        n = 0;
        while (cpu_en !== 1'b1 && n++ < 50) @(posedge clk_sys);
        chk(32'(n >= WK - 1 && n <= WK + 8), 32'h1, "wake delay");
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h4, "mode kept");
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h3, "after idle");
        $display("done: idle");
        wb(1'b1, 4'h4, 32'h0);
        wb(1'b1, 4'h0, 32'h1);
        wb(1'b1, 4'hc, 32'h1);
        wt(4);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h3, "refused");
        $display("done: refusal");
        sec_dly <= 8'h14;
        // Sleep before the secondary has started, on purpose
        wb(1'b1, 4'h4, 32'h8);
        ev(3'h1);
        wt(3);
        chk({pri_en, gate}, 4'h0, "held off");
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h48, "active flag");
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h32, "sec status");
        wgate(3'h2);
        pri_dly <= 8'h14;
        ev(3'h2);
        wt(3);
        chk(gate, 3'h2, "sec keeps clock");
        wgate(3'h1);
        chk(sec_en, 1'b1, "sec left running");
        wb(1'b0, 4'h4, 32'h0);
        chk(q, 32'h8, "flag cleared");
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h1, "select kept");
        $display("done: secondary wake");
        ev(3'h1);
        wgate(3'h2);
        wb(1'b1, 4'h4, 32'h0);
        wt(3);
        chk({pri_en, gate}, 4'ha, "forced exit");
        wgate(3'h1);
        wt(2);
        chk(sec_en, 1'b0, "sec stopped");
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h3, "forced status");
        $display("done: forced exit");
        wb(1'b1, 4'h0, 32'h2);
        ev(3'h1);
        wt(2);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h52, "internal run");
        wgate(3'h4);
        ev(3'h4);
        wt(3);
        chk(wdt_seen, 1'b1, "wdt reset");
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h3, "back to primary");
        wgate(3'h1);
        $display("done: watchdog");
        wb(1'b1, 4'h4, 32'h8);
        wb(1'b1, 4'h0, 32'h1);
        ev(3'h1);
        wt(30);
        rst_n <= 1'b0;
        wt(2);
        rst_n <= 1'b1;
        wt(4);
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h3, "reset exit");
        intosc_pri <= 1'b0;
        wb(1'b0, 4'h8, 32'h0);
        chk(q, 32'h1, "intosc flag off");
        $display("done: reset");
        end_sim;
    end
    initial
    begin
        wt(20000);
        miscompares++;
        end_sim;
    end
endmodule
